// File: hdl/fhi_interposer.sv
// flush handshake interposer: sits on the flush line between system component and bus bridge
// assumes one clock (the pci clock) and pins sampled synchronously; lines are active low
// with pull-ups, so a released line reads negated unless the far party drives it
//
// Summary of operation
// - system-side line asserted only while a0 low and pci reset inactive
// - system-side driver enabled except in code a1=0,a0=1, where it floats
// - bridge-side line asserted only while b1 low and pci reset inactive
// - pci reset sends machine A to idle on the next clock
// - idle moves to waiting when system-side line sampled asserted
// - waiting moves to flushing when bridge-side line sampled asserted
// - flushing goes to release on bridge negation; release returns to idle
// - all state bits of both machines register on the pci clock
// - machine A codes: idle 01, waiting 00, flushing 10, release 11
// - machine B waits for hold acknowledge low, then asserts one clock
// - after flush, A drives negated then floats; B drives negated default
`timescale 1ns/1ps

module fhi_interposer (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_pci_reset_in,
    input wire logic i_bus_hold_acknowledge,
    input wire logic i_flush_line_sys_side_n,
    output logic o_flush_line_sys_side_n,
    output logic o_sys_side_drive_enable,
    input wire logic i_flush_line_bridge_side_n,
    output logic o_flush_line_bridge_side_n,
    output logic o_flush_line_bridge_side_oe,
    output logic o_state_a_bit0,
    output logic o_state_a_bit1,
    output logic o_state_b_bit0,
    output logic o_state_b_bit1
);

    typedef struct packed {
        fhi_pkg::fhi_a_state_type state;
    } fhi_a_regs_type;

    fhi_a_regs_type a_reg;
    fhi_a_regs_type a_next;
    logic [1:0] a_code;
    logic sys_flush_seen;
    logic bridge_flush_seen;
    logic sys_side_flush_out;
    logic bridge_side_flush_out;
    logic flush_pending;

    // map state to its documented bit code
    function automatic logic [1:0] fhi_a_code(input fhi_pkg::fhi_a_state_type s);
        case (s)
            fhi_pkg::A_IDLE: fhi_a_code = fhi_pkg::A_IDLE_CODE;
            fhi_pkg::A_WAITING: fhi_a_code = fhi_pkg::A_WAITING_CODE;
            fhi_pkg::A_FLUSHING: fhi_a_code = fhi_pkg::A_FLUSHING_CODE;
            fhi_pkg::A_RELEASE: fhi_a_code = fhi_pkg::A_RELEASE_CODE;
            default: fhi_a_code = fhi_pkg::A_IDLE_CODE;
        endcase
    endfunction

    // ==========================================================
    // pin sampling
    // ==========================================================
    // line levels as seen on the wire, including our own drive
    assign sys_flush_seen = (i_flush_line_sys_side_n == fhi_pkg::LINE_ASSERTED_LEVEL);
    assign bridge_flush_seen = (i_flush_line_bridge_side_n == fhi_pkg::LINE_ASSERTED_LEVEL);

    // ==========================================================
    // state machine A: emulates the bridge towards the system side
    // ==========================================================
    always_comb begin
        a_next = a_reg;
        if (i_pci_reset_in) begin
            a_next.state = fhi_pkg::A_IDLE;
        end else begin
            case (a_reg.state)
                fhi_pkg::A_IDLE: begin
                    if (sys_flush_seen) begin
                        a_next.state = fhi_pkg::A_WAITING;
                    end
                end
                fhi_pkg::A_WAITING: begin
                    if (bridge_flush_seen) begin
                        a_next.state = fhi_pkg::A_FLUSHING;
                    end
                end
                fhi_pkg::A_FLUSHING: begin
                    if (!bridge_flush_seen) begin
                        a_next.state = fhi_pkg::A_RELEASE;
                    end
                end
                fhi_pkg::A_RELEASE: begin
                    a_next.state = fhi_pkg::A_IDLE;
                end
                default: begin
                    a_next.state = fhi_pkg::A_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            a_reg <= '{state: fhi_pkg::A_IDLE};
        end else begin
            a_reg <= a_next;
        end
    end

    assign a_code = fhi_a_code(a_reg.state);
    assign o_state_a_bit0 = a_code[fhi_pkg::BIT0_POS];
    assign o_state_a_bit1 = a_code[fhi_pkg::BIT1_POS];

    // ==========================================================
    // system-side pin drive
    // ==========================================================
    // assert while a0 low
    assign sys_side_flush_out = !o_state_a_bit0 && !i_pci_reset_in;
    assign o_flush_line_sys_side_n = !sys_side_flush_out;
    // release drives negated before idle floats
    assign o_sys_side_drive_enable = !(!o_state_a_bit1 && o_state_a_bit0);

    // ==========================================================
    // state machine B: emulates the system side towards the bridge
    // ==========================================================
    // request stands while A holds the system side waiting
    assign flush_pending = (a_reg.state == fhi_pkg::A_WAITING);

    fhi_bridge_fsm u_bridge_fsm (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_pci_reset_in(i_pci_reset_in),
        .i_bus_hold_acknowledge(i_bus_hold_acknowledge),
        .i_flush_pending(flush_pending),
        .i_bridge_flush_seen(bridge_flush_seen),
        .o_state_b_bit0(o_state_b_bit0),
        .o_state_b_bit1(o_state_b_bit1)
    );

    // ==========================================================
    // bridge-side pin drive
    // ==========================================================
    // assert while b1 low
    assign bridge_side_flush_out = !o_state_b_bit1 && !i_pci_reset_in;
    assign o_flush_line_bridge_side_n = !bridge_side_flush_out;
    assign o_flush_line_bridge_side_oe = !o_state_b_bit0;

endmodule

// File: hdl/fhi_pkg.sv
// constants shared by the flush handshake interposer and its bridge-side state machine
// assumes a single clock; both flush line levels are active low at the pins
package fhi_pkg;

    // ==========================================================
    // state bit encodings, state machine A (bits [1:0] = a1,a0)
    // ==========================================================
    localparam logic [1:0] A_IDLE_CODE = 2'h1;
    localparam logic [1:0] A_WAITING_CODE = 2'h0;
    localparam logic [1:0] A_FLUSHING_CODE = 2'h2;
    localparam logic [1:0] A_RELEASE_CODE = 2'h3;

    // ==========================================================
    // state bit encodings, state machine B (bits [1:0] = b1,b0)
    // ==========================================================
    localparam logic [1:0] B_DEFAULT_CODE = 2'h2;
    localparam logic [1:0] B_PULSE_CODE = 2'h0;
    localparam logic [1:0] B_RELEASED_CODE = 2'h1;
    localparam logic [1:0] B_DONE_CODE = 2'h3;

    // ==========================================================
    // bit positions inside a state code
    // ==========================================================
    localparam int BIT0_POS = 0;
    localparam int BIT1_POS = 1;

    // pin level meaning asserted on an active-low flush line
    localparam logic LINE_ASSERTED_LEVEL = 1'h0;

    // ==========================================================
    // state types
    // ==========================================================
    typedef enum logic [1:0] {
        A_IDLE,
        A_WAITING,
        A_FLUSHING,
        A_RELEASE
    } fhi_a_state_type;

    typedef enum logic [1:0] {
        B_DEFAULT,
        B_PULSE,
        B_RELEASED,
        B_DONE
    } fhi_b_state_type;

endpackage

// File: hdl/fhi_bridge_fsm.sv
// state machine B: drives the bridge-side flush line on behalf of the system side
// assumes inputs synchronous to i_sys_clk; the bridge owns the line while released
`timescale 1ns/1ps

module fhi_bridge_fsm (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_pci_reset_in,
    input wire logic i_bus_hold_acknowledge,
    input wire logic i_flush_pending,
    input wire logic i_bridge_flush_seen,
    output logic o_state_b_bit0,
    output logic o_state_b_bit1
);

    typedef struct packed {
        fhi_pkg::fhi_b_state_type state;
    } fhi_b_regs_type;

    fhi_b_regs_type b_reg;
    fhi_b_regs_type b_next;
    logic [1:0] b_code;

    // map state to its documented bit code
    function automatic logic [1:0] fhi_b_code(input fhi_pkg::fhi_b_state_type s);
        case (s)
            fhi_pkg::B_DEFAULT: fhi_b_code = fhi_pkg::B_DEFAULT_CODE;
            fhi_pkg::B_PULSE: fhi_b_code = fhi_pkg::B_PULSE_CODE;
            fhi_pkg::B_RELEASED: fhi_b_code = fhi_pkg::B_RELEASED_CODE;
            fhi_pkg::B_DONE: fhi_b_code = fhi_pkg::B_DONE_CODE;
            default: fhi_b_code = fhi_pkg::B_DEFAULT_CODE;
        endcase
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        b_next = b_reg;
        if (i_pci_reset_in) begin
            b_next.state = fhi_pkg::B_DEFAULT;
        end else begin
            case (b_reg.state)
                fhi_pkg::B_DEFAULT: begin
                    if (i_flush_pending && !i_bus_hold_acknowledge) begin
                        b_next.state = fhi_pkg::B_PULSE;
                    end
                end
                fhi_pkg::B_PULSE: begin
                    b_next.state = fhi_pkg::B_RELEASED;
                end
                fhi_pkg::B_RELEASED: begin
                    if (!i_bridge_flush_seen) begin
                        b_next.state = fhi_pkg::B_DONE;
                    end
                end
                fhi_pkg::B_DONE: begin
                    b_next.state = fhi_pkg::B_DEFAULT;
                end
                default: begin
                    b_next.state = fhi_pkg::B_DEFAULT;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            b_reg <= '{state: fhi_pkg::B_DEFAULT};
        end else begin
            b_reg <= b_next;
        end
    end

    // state bit outputs
    assign b_code = fhi_b_code(b_reg.state);
    assign o_state_b_bit0 = b_code[fhi_pkg::BIT0_POS];
    assign o_state_b_bit1 = b_code[fhi_pkg::BIT1_POS];

endmodule

// File: bench/fhi_interposer_assertions.sv
// checker watching the top ports of the flush handshake interposer
// assumes one clock and the asynchronous active-high reset of the top
`timescale 1ns/1ps
module fhi_interposer_checker (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_pci_reset_in,
    input wire logic i_bus_hold_acknowledge,
    input wire logic i_flush_line_sys_side_n,
    input wire logic o_flush_line_sys_side_n,
    input wire logic o_sys_side_drive_enable,
    input wire logic i_flush_line_bridge_side_n,
    input wire logic o_flush_line_bridge_side_n,
    input wire logic o_flush_line_bridge_side_oe,
    input wire logic o_state_a_bit0,
    input wire logic o_state_a_bit1,
    input wire logic o_state_b_bit0,
    input wire logic o_state_b_bit1
);
    // ==========================================================
    // short views of the state and line signals
    logic [1:0] st_a;
    logic [1:0] st_b;
    logic br_low;
    assign st_a = {o_state_a_bit1, o_state_a_bit0};
    assign st_b = {o_state_b_bit1, o_state_b_bit0};
    assign br_low = o_flush_line_bridge_side_oe && !o_flush_line_bridge_side_n;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================================
    // line drivers and state machine checks
    sys_drive_level_a: assert property (o_sys_side_drive_enable |->
        o_flush_line_sys_side_n == (o_state_a_bit0 | i_pci_reset_in)) else $error("system line level wrong");
    sys_float_code_a: assert property (o_sys_side_drive_enable == (st_a != 2'h1))
        else $error("system line enable wrong");
    bridge_drive_level_a: assert property (o_flush_line_bridge_side_oe |->
        o_flush_line_bridge_side_n == (o_state_b_bit1 | i_pci_reset_in)) else $error("bridge line level wrong");
    bridge_oe_code_a: assert property (o_flush_line_bridge_side_oe == !o_state_b_bit0)
        else $error("bridge line enable wrong");
    pci_reset_idle_a: assert property (i_pci_reset_in |=> st_a == 2'h1 && st_b == 2'h2)
        else $error("pci reset did not idle");
    idle_request_a: assert property (st_a == 2'h1 && !i_pci_reset_in |=>
        st_a == ($past(i_flush_line_sys_side_n) ? 2'h1 : 2'h0)) else $error("idle step wrong");
    wait_advance_a: assert property (st_a == 2'h0 && !i_pci_reset_in |=>
        st_a == ($past(i_flush_line_bridge_side_n) ? 2'h0 : 2'h2)) else $error("waiting step wrong");
    flush_advance_a: assert property (st_a == 2'h2 && !i_pci_reset_in && i_flush_line_bridge_side_n
        |=> st_a == 2'h3 ##1 st_a == 2'h1) else $error("flushing exit wrong");
    pulse_one_clock_a: assert property (br_low |=> !br_low)
        else $error("bridge pulse too long");
    pulse_bus_free_a: assert property ($rose(br_low) |-> !$past(i_bus_hold_acknowledge))
        else $error("bridge pulse while bus busy");
    // ==========================================================
    // main scenarios reached
    cover property (st_a == 2'h3);
    cover property (br_low);
    cover property (i_pci_reset_in && st_a == 2'h0);
endmodule

bind fhi_interposer fhi_interposer_checker u_chk (.i_sys_clk, .i_sys_rst, .i_pci_reset_in, .i_bus_hold_acknowledge,
    .i_flush_line_sys_side_n, .o_flush_line_sys_side_n, .o_sys_side_drive_enable, .i_flush_line_bridge_side_n,
    .o_flush_line_bridge_side_n, .o_flush_line_bridge_side_oe, .o_state_a_bit0, .o_state_a_bit1,
    .o_state_b_bit0, .o_state_b_bit1);

// File: bench/fhi_far_side_model.sv
// model of the system party and the bus bridge on the two flush lines
// assumes pulled-up lines: a pull output high means this party drives low
`timescale 1ns/1ps
module fhi_far_side_model (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic [3:0] i_hold_len,
    input wire logic i_bridge_line_n,
    output logic o_sys_pull_low,
    output logic o_bridge_pull_low
);
    logic [3:0] cnt_reg;
    // system party drives low only in the request cycle
    assign o_sys_pull_low = i_req;
    assign o_bridge_pull_low = (cnt_reg != 4'h0);
    // bridge holds the line low while its buffers flush
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) cnt_reg <= 4'h0;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
        else if (!i_bridge_line_n) cnt_reg <= i_hold_len;
    end
endmodule

// File: bench/fhi_interposer_tb_top.sv
// self-checking bench for the flush handshake interposer
// assumes the far side model and the bound checker; lines resolved here
`timescale 1ns/1ps
module fhi_interposer_tb_top;
    typedef struct {int busy; int hold; int exp_low;} fhi_row_type;
    logic i_sys_clk = 1'h0;
    logic i_sys_rst = 1'h1;
    logic pci_rst = 1'h0;
    logic hold_ack = 1'h0;
    logic req = 1'h0;
    logic [3:0] hold_len = 4'h1;
    logic cnt_clr = 1'h0;
    logic sys_out_n, sys_oe, br_out_n, br_oe, a0, a1, b0, b1, m_sys, m_br, sys_line_n, br_line_n;
    int n_errors = 0;
    int samples_checked = 0;
    int n_sys_low = 0;
    int n_pulse = 0;
    int cycles = 0;
    fhi_row_type rows[4] = '{'{0, 1, 4}, '{2, 3, 8}, '{5, 1, 9}, '{1, 8, 12}};
    // pulled-up wires seen by every party
    assign sys_line_n = !((sys_oe && !sys_out_n) || m_sys);
    assign br_line_n = !((br_oe && !br_out_n) || m_br);
    fhi_interposer u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_pci_reset_in(pci_rst),
        .i_bus_hold_acknowledge(hold_ack), .i_flush_line_sys_side_n(sys_line_n), .o_flush_line_sys_side_n(sys_out_n),
        .o_sys_side_drive_enable(sys_oe), .i_flush_line_bridge_side_n(br_line_n),
        .o_flush_line_bridge_side_n(br_out_n), .o_flush_line_bridge_side_oe(br_oe), .o_state_a_bit0(a0),
        .o_state_a_bit1(a1), .o_state_b_bit0(b0), .o_state_b_bit1(b1));
    fhi_far_side_model u_far (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_hold_len(hold_len),
        .i_bridge_line_n(br_line_n), .o_sys_pull_low(m_sys), .o_bridge_pull_low(m_br));
    // ==========================================================
    // clock, driven-low cycle counts and timeout
    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        // counters cleared here only, so each has a single writer
        if (cnt_clr) begin
            n_sys_low <= 0;
            n_pulse <= 0;
        end else begin
            if (sys_oe && !sys_out_n) n_sys_low <= n_sys_low + 1;
            if (br_oe && !br_out_n) n_pulse <= n_pulse + 1;
        end
        if (cycles == 1000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end
    // ==========================================================
    // compare, verdict and one whole handshake
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic run_row(input fhi_row_type r);
        @(posedge i_sys_clk);
        hold_ack <= 1'h1;
        req <= 1'h1;
        hold_len <= r.hold[3:0];
        cnt_clr <= 1'h1;
        @(posedge i_sys_clk);
        cnt_clr <= 1'h0;
        req <= 1'h0;
        repeat (r.busy) @(posedge i_sys_clk);
        hold_ack <= 1'h0;
        repeat (r.hold + 8) @(posedge i_sys_clk);
        check(n_sys_low[7:0], r.exp_low[7:0]);
        check(n_pulse[7:0], 8'h01);
        check({4'h0, a1, a0, b1, b0}, 8'h06);
    endtask
    // ==========================================================
    // table of handshakes, then reset cases
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_sys_rst <= 1'h0;
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("handshake row %0d done", i);
        end
        @(posedge i_sys_clk);
        i_sys_rst <= 1'h1;
        #1 check({1'h0, a1, a0, b1, b0, sys_oe, br_oe, br_out_n}, 8'h33);
        @(posedge i_sys_clk);
        i_sys_rst <= 1'h0;
        $display("reset test done");
        // request with the bus free, then pci reset lands in the bridge pulse
        @(posedge i_sys_clk);
        cnt_clr <= 1'h1;
        req <= 1'h1;
        @(posedge i_sys_clk);
        cnt_clr <= 1'h0;
        req <= 1'h0;
        @(posedge i_sys_clk);
        pci_rst <= 1'h1;
        #1 check({4'h0, sys_oe, sys_out_n, br_oe, br_out_n}, 8'h0F);
        @(posedge i_sys_clk);
        pci_rst <= 1'h0;
        hold_ack <= 1'h0;
        #1 check({4'h0, a1, a0, b1, b0}, 8'h06);
        repeat (3) @(posedge i_sys_clk);
        check({7'h0, n_pulse == 0}, 8'h01);
        $display("pci reset test done");
        wrap_up();
    end
endmodule
